// ---- logic/ufc_defines.svh ----
// offsets, field positions, reset values and trigger levels of the fifo control block
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH
`define UFC_FIFO_CONTROL_ADDR 3'h2
`define UFC_FIFO_CONTROL_RESET 8'h00
`define UFC_RX_SEL_HI 7
`define UFC_RX_SEL_LO 6
`define UFC_TX_SEL_HI 5
`define UFC_TX_SEL_LO 4
`define UFC_DMA_BIT 3
`define UFC_TX_CLR_BIT 2
`define UFC_RX_CLR_BIT 1
`define UFC_ENABLE_BIT 0
`define UFC_RX_LEVEL_0 7'h08
`define UFC_RX_LEVEL_1 7'h10
`define UFC_RX_LEVEL_2 7'h38
`define UFC_RX_LEVEL_3 7'h3C
`define UFC_TX_LEVEL_0 7'h08
`define UFC_TX_LEVEL_1 7'h10
`define UFC_TX_LEVEL_2 7'h20
`define UFC_TX_LEVEL_3 7'h38
`endif

// ---- logic/ufc_pkg.sv ----
// types shared by the fifo control block
`default_nettype none
package ufc_pkg;
  typedef enum logic {
    UFC_DMA_MODE0 = 1'b0,
    UFC_DMA_MODE1 = 1'b1
  } ufc_dma_mode_t;
  typedef logic [1:0] ufc_trig_code_t;
endpackage
`default_nettype wire

// ---- logic/ufc_fifo.sv ----
// byte fifo with clear, single-location mode when disabled, optional overwrite in that mode only
`default_nettype none
module ufc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic fifo_en,
  input wire logic overwrite,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] pop_data,
  output logic pop_valid,
  output logic [AW:0] count
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] cap;
  logic full;
  logic do_push;
  logic do_pop;
  logic grow;

  assign cap = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign full = count >= cap;
  // disabled receive side overwrites location zero; otherwise a full fifo drops the byte
  assign do_push = push && (!full || (overwrite && !fifo_en)); // RL11 RL12
  assign do_pop = pop && (count != '0);
  assign grow = do_push && !full;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[fifo_en ? wr_ptr : '0] <= push_data; // RL11 RL12
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (fifo_en && do_push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (fifo_en && do_pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(grow) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pop_data <= '0;
      pop_valid <= 1'b0;
    end else begin
      pop_valid <= do_pop && !clear;
      if (do_pop) begin
        pop_data <= mem[fifo_en ? rd_ptr : '0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/ufc_top.sv ----
// fifo control register of one uart channel with its transmit and receive fifos
`include "ufc_defines.svh"
`default_nettype none
// Behaviour
// RL1: the control register is write only; it has no read path.
// RL2: bits 7-6 pick receive threshold 8, 16, 56 or 60 characters.
// RL3: bits 5-4 pick transmit threshold 8, 16, 32 or 56 free spaces.
// RL4: transmit threshold field is written and used only with enhanced functions enabled.
// RL5: bit 3 selects dma signalling mode 0 or 1.
// RL6: writing 1 to bit 2 empties the transmit fifo, then self-clears.
// RL7: writing 1 to bit 1 empties the receive fifo, then self-clears.
// RL8: bit 0 set enables both fifos together.
// RL9: bit 0 clear disables both fifos; disabled after reset.
// RL10: clear bits are inactive after reset; no clearing until requested.
// RL11: disabled receive fifo keeps characters in location zero, overwriting on overflow.
// RL12: disabled transmit fifo still stores the byte; overflow bytes are lost.
// RL13: triggers assert when fill or free count reaches the selected threshold.
module ufc_top #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_cs,
  input wire logic bus_wr,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic enhanced_function_enable,
  input wire logic rx_push,
  input wire logic [7:0] rx_char,
  input wire logic rx_pop,
  output logic [7:0] rx_data,
  output logic rx_data_valid,
  input wire logic tx_push,
  input wire logic [7:0] tx_char,
  input wire logic tx_pop,
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  output logic fifo_enable,
  output ufc_pkg::ufc_dma_mode_t dma_mode,
  output ufc_pkg::ufc_trig_code_t rx_threshold_sel,
  output ufc_pkg::ufc_trig_code_t tx_threshold_sel,
  output logic rx_fifo_cleared,
  output logic tx_fifo_cleared,
  output logic rx_trigger,
  output logic tx_trigger,
  output logic [AW:0] rx_count,
  output logic [AW:0] tx_count
);
  import ufc_pkg::*;

  logic fcr_wr;
  logic enable_change;
  logic [AW:0] tx_free;

  function automatic logic is_write(input logic cs, input logic wr, input logic [2:0] addr);
    is_write = cs && wr && (addr == `UFC_FIFO_CONTROL_ADDR);
  endfunction

  function automatic logic [AW:0] rx_level(input ufc_trig_code_t code);
    case (code)
      2'h0: rx_level = (AW+1)'(`UFC_RX_LEVEL_0);
      2'h1: rx_level = (AW+1)'(`UFC_RX_LEVEL_1);
      2'h2: rx_level = (AW+1)'(`UFC_RX_LEVEL_2);
      default: rx_level = (AW+1)'(`UFC_RX_LEVEL_3);
    endcase
  endfunction

  function automatic logic [AW:0] tx_level(input ufc_trig_code_t code);
    case (code)
      2'h0: tx_level = (AW+1)'(`UFC_TX_LEVEL_0);
      2'h1: tx_level = (AW+1)'(`UFC_TX_LEVEL_1);
      2'h2: tx_level = (AW+1)'(`UFC_TX_LEVEL_2);
      default: tx_level = (AW+1)'(`UFC_TX_LEVEL_3);
    endcase
  endfunction

  // writes only; the block drives no data back to the host
  assign fcr_wr = is_write(bus_cs, bus_wr, bus_addr); // RL1

  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_enable <= 1'(`UFC_FIFO_CONTROL_RESET >> `UFC_ENABLE_BIT); // RL9
      dma_mode <= UFC_DMA_MODE0;
      rx_threshold_sel <= 2'h0;
      enable_change <= 1'b0;
    end else begin
      enable_change <= fcr_wr && (bus_wdata[`UFC_ENABLE_BIT] != fifo_enable);
      if (fcr_wr) begin
        fifo_enable <= bus_wdata[`UFC_ENABLE_BIT]; // RL8 RL9
        dma_mode <= ufc_dma_mode_t'(bus_wdata[`UFC_DMA_BIT]); // RL5
        rx_threshold_sel <= bus_wdata[`UFC_RX_SEL_HI:`UFC_RX_SEL_LO]; // RL2
      end
    end
  end

  // without enhanced functions the field is held at its reset code
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_threshold_sel <= 2'h0;
    end else if (!enhanced_function_enable) begin
      tx_threshold_sel <= 2'h0; // RL4
    end else if (fcr_wr) begin
      tx_threshold_sel <= bus_wdata[`UFC_TX_SEL_HI:`UFC_TX_SEL_LO]; // RL3 RL4
    end
  end

  // self-clearing clear bits: high for one cycle per write of a 1
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_fifo_cleared <= 1'b0; // RL10
      rx_fifo_cleared <= 1'b0; // RL10
    end else begin
      tx_fifo_cleared <= fcr_wr && bus_wdata[`UFC_TX_CLR_BIT]; // RL6
      rx_fifo_cleared <= fcr_wr && bus_wdata[`UFC_RX_CLR_BIT]; // RL7
    end
  end

  ufc_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .clear(rx_fifo_cleared || enable_change), // RL7
    .fifo_en(fifo_enable),
    .overwrite(1'b1),
    .push(rx_push),
    .push_data(rx_char),
    .pop(rx_pop),
    .pop_data(rx_data),
    .pop_valid(rx_data_valid),
    .count(rx_count)
  );

  ufc_fifo #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .clear(tx_fifo_cleared || enable_change), // RL6
    .fifo_en(fifo_enable),
    .overwrite(1'b0),
    .push(tx_push),
    .push_data(tx_char),
    .pop(tx_pop),
    .pop_data(tx_data),
    .pop_valid(tx_data_valid),
    .count(tx_count)
  );

  assign tx_free = (AW+1)'(DEPTH) - tx_count;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_trigger <= 1'b0;
      tx_trigger <= 1'b0;
    end else begin
      rx_trigger <= rx_count >= rx_level(rx_threshold_sel); // RL13
      tx_trigger <= tx_free >= tx_level(tx_threshold_sel); // RL13
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_tx_clear;
    tx_fifo_cleared ##1 (tx_count == '0);
  endsequence

  sequence s_rx_clear;
    rx_fifo_cleared ##1 (rx_count == '0);
  endsequence

  a_rx_thresh_load: assert property (fcr_wr |=> rx_threshold_sel == $past(bus_wdata[7:6])) // RL2
    else $error("receive threshold not loaded");
  a_tx_thresh_load: assert property (fcr_wr && enhanced_function_enable |=> tx_threshold_sel == $past(bus_wdata[5:4])) // RL3
    else $error("transmit threshold not loaded");
  a_tx_thresh_gate: assert property (!enhanced_function_enable |=> tx_threshold_sel == 2'h0) // RL4
    else $error("transmit threshold active without enhanced functions");
  a_dma_select: assert property (fcr_wr |=> dma_mode == ufc_dma_mode_t'($past(bus_wdata[3]))) // RL5
    else $error("dma mode not taken");
  a_tx_clear_seq: assert property (fcr_wr && bus_wdata[2] |=> s_tx_clear) // RL6
    else $error("transmit fifo not emptied");
  a_rx_clear_seq: assert property (fcr_wr && bus_wdata[1] |=> s_rx_clear) // RL7
    else $error("receive fifo not emptied");
  a_clear_selfclr: assert property (tx_fifo_cleared || rx_fifo_cleared |-> $past(fcr_wr)) // RL10
    else $error("clear pulse without write");
  a_enable_both: assert property (fcr_wr |=> fifo_enable == $past(bus_wdata[0])) // RL8
    else $error("fifo enable not taken");
  a_disabled_single: assert property (!fifo_enable && $past(!fifo_enable) |-> rx_count <= 1 && tx_count <= 1) // RL11
    else $error("disabled fifo holds more than one byte");
  a_rx_trigger: assert property (rx_trigger == ($past(rx_count) >= rx_level($past(rx_threshold_sel)))) // RL13
    else $error("receive trigger wrong");
  a_tx_trigger_empty: assert property (tx_count == '0 |=> tx_trigger) // RL13
    else $error("transmit trigger low with empty fifo");
endmodule
`default_nettype wire

// ---- verification/ufc_host.sv ----
// host processor model that writes the fifo control block over the byte bus
`default_nettype none
module ufc_host (
  input wire logic clk,
  output logic bus_cs,
  output logic bus_wr,
  output logic [2:0] bus_addr,
  output logic [7:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_cs = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 3'h0;
    bus_wdata = 8'h00;
  end
  // one-cycle strobe; released lines show the inverse so stale values never pass
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_cs = 1'b1;
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk);
    bus_cs = 1'b0;
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench of the fifo control block
`include "ufc_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, efe = 1'b0, rx_push = 1'b0, rx_pop = 1'b0, tx_push = 1'b0, tx_pop = 1'b0;
  logic [7:0] rx_char = 8'h00, tx_char = 8'h00, rx_data, tx_data, bus_wdata;
  logic [2:0] bus_addr;
  logic bus_cs, bus_wr, rx_data_valid, tx_data_valid, fifo_enable, rx_fifo_cleared, tx_fifo_cleared;
  logic rx_trigger, tx_trigger;
  ufc_pkg::ufc_dma_mode_t dma_mode;
  ufc_pkg::ufc_trig_code_t rx_threshold_sel, tx_threshold_sel;
  logic [6:0] rx_count, tx_count;
  int errors = 0, cmp_count = 0;
  int rx_lv[4] = '{8, 16, 56, 60};
  int tx_lv[4] = '{8, 16, 32, 56};
  always #2 clk = ~clk;
  ufc_host host (.clk(clk), .bus_cs(bus_cs), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  ufc_top DUT (.clk(clk), .rst(rst), .bus_cs(bus_cs), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .enhanced_function_enable(efe), .rx_push(rx_push), .rx_char(rx_char),
    .rx_pop(rx_pop), .rx_data(rx_data), .rx_data_valid(rx_data_valid), .tx_push(tx_push),
    .tx_char(tx_char), .tx_pop(tx_pop), .tx_data(tx_data), .tx_data_valid(tx_data_valid),
    .fifo_enable(fifo_enable), .dma_mode(dma_mode), .rx_threshold_sel(rx_threshold_sel),
    .tx_threshold_sel(tx_threshold_sel), .rx_fifo_cleared(rx_fifo_cleared),
    .tx_fifo_cleared(tx_fifo_cleared), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger),
    .rx_count(rx_count), .tx_count(tx_count));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    host.write(`UFC_FIFO_CONTROL_ADDR, d);
  endtask
  task automatic push(input bit tx, input logic [7:0] d);
    @(negedge clk);
    if (tx) {tx_push, tx_char} = {1'b1, d};
    else {rx_push, rx_char} = {1'b1, d};
    @(negedge clk);
    {tx_push, rx_push, tx_char, rx_char} = {2'b00, ~d, ~d};
  endtask
  // data and valid are looked at in the cycle after the pop edge
  task automatic pop(input bit tx);
    @(negedge clk);
    if (tx) tx_pop = 1'b1;
    else rx_pop = 1'b1;
    @(negedge clk);
    {tx_pop, rx_pop} = 2'b00;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({fifo_enable, dma_mode, rx_threshold_sel, tx_threshold_sel, rx_fifo_cleared, tx_fifo_cleared}, 8'h00);
    chk({tx_trigger, rx_count}, 8'h80);
    host.write(3'h3, 8'h01);
    chk({7'h00, fifo_enable}, 8'h00);
    wr(8'hF8);
    chk({3'h0, rx_threshold_sel, tx_threshold_sel, dma_mode}, 8'h19);
    efe = 1'b1;
    wr(8'h31);
    chk({2'h0, fifo_enable, rx_threshold_sel, tx_threshold_sel, dma_mode}, 8'h26);
    $display("field test done");
    for (int c = 0; c < 4; c++) begin
      wr({c[1:0], c[1:0], 4'h7});
      repeat (2) @(negedge clk);
      for (int i = 1; i < rx_lv[c]; i++) push(1'b0, i[7:0]);
      @(negedge clk);
      chk({rx_trigger, rx_count}, 8'(rx_lv[c] - 1));
      push(1'b0, 8'hA5);
      @(negedge clk);
      chk({7'h00, rx_trigger}, 8'h01);
      for (int i = 0; i <= 64 - tx_lv[c]; i++) push(1'b1, i[7:0]);
      @(negedge clk);
      chk({7'h00, tx_trigger}, 8'h00);
      pop(1'b1);
      chk({tx_data_valid, tx_data[6:0]}, 8'h80);
      @(negedge clk);
      chk({7'h00, tx_trigger}, 8'h01);
    end
    $display("threshold test done");
    wr(8'h05);
    chk({6'h00, rx_fifo_cleared, tx_fifo_cleared}, 8'h01);
    @(negedge clk);
    chk({tx_fifo_cleared, tx_count}, 8'h00);
    chk({rx_fifo_cleared, rx_count}, 8'd60);
    wr(8'h03);
    chk({6'h00, rx_fifo_cleared, tx_fifo_cleared}, 8'h02);
    @(negedge clk);
    chk({rx_fifo_cleared, rx_count}, 8'h00);
    $display("clear test done");
    wr(8'h00);
    repeat (2) @(negedge clk);
    push(1'b0, 8'h0B);
    push(1'b0, 8'h16);
    chk({fifo_enable, rx_count}, 8'h01);
    pop(1'b0);
    chk(rx_data, 8'h16);
    chk({7'h00, rx_data_valid}, 8'h01);
    push(1'b1, 8'h21);
    push(1'b1, 8'h2C);
    chk({1'b0, tx_count}, 8'h01);
    pop(1'b1);
    chk({tx_data_valid, tx_data[6:0]}, 8'hA1);
    $display("disabled test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
